// >>> rtl/tael_logger.sv
// How it works
// - open of first switch not done in 3 s raises alarm 1, blinking
// - open of second switch not done in 3 s raises alarm 2, blinking
// - secondary load disconnect not done in 3 s raises alarm 4, blinking
// - close of first switch not done in 3 s raises alarm 8, blinking
// - close of second switch not done in 3 s raises alarm 16, blinking
// - secondary load connect not done in 3 s raises alarm 32, blinking
// - failed movement alarms clear only on an automatic-mode key press
// - mounted handle gives forced-manual alarm 256 while mounted
// - both position inputs active gives external fault alarm 512
// - generator malfunction gives generator alarm 4096
// - first supply events coded 0 to 6
// - second supply missing voltage coded 7, undervoltage coded 8
// - every alarm and event becomes its own entry in one shared log
// - log bit 15 kind; events code 14:8 source 7:0; alarms code 12:0
// - event source field holds 1 to 6 by origin
// - any movement failure locks automatic switching until key press
`timescale 1ns/1ns
module tael_logger #(
  parameter int unsigned TIMEOUT_CYC = tael_pkg::TIMEOUT_CYC,
  parameter int unsigned BLINK_CYC   = tael_pkg::BLINK_CYC,
  parameter int unsigned LOG_DEPTH   = tael_pkg::LOG_DEPTH,
  parameter int unsigned LOG_AW      = $clog2(LOG_DEPTH)
) (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // movement commands from the switching logic, one-cycle pulses
  input  wire tael_pkg::tael_cmd_s    move_cmd,
  // switch mechanism and front panel pins, asynchronous
  input  wire tael_pkg::tael_pins_s   pins,
  // supply supervision conditions, levels
  input  wire logic [6:0]             first_supply_cond,
  input  wire logic [1:0]             second_supply_cond,
  input  wire tael_pkg::tael_src_e    event_src,
  // alarm state and indicator
  output logic      [12:0]            alarm_code_ff,
  output logic                        alarm_led_ff,
  output logic                        auto_lock_ff,
  // log stream and log read port
  output logic                        log_wr_ff,
  output logic      [15:0]            log_word_ff,
  output logic      [LOG_AW-1:0]      log_wptr_ff,
  input  wire logic [LOG_AW-1:0]      log_rd_addr,
  output logic      [15:0]            log_rd_data
);

  localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);
  localparam int unsigned BW = $clog2(BLINK_CYC + 1);
  localparam int unsigned PW = tael_pkg::ALM_W + tael_pkg::EV_N;
  localparam int unsigned MN = tael_pkg::MOVE_N;

  function automatic logic [6:0] ev_index(input logic [tael_pkg::EV_N-1:0] oh);
    logic [6:0] idx;
    idx = 7'h00;
    for (int k = 0; k < tael_pkg::EV_N; k++) begin
      if (oh[k]) begin
        idx = 7'(k);
      end
    end
    return idx;
  endfunction : ev_index

  // ---- pin synchronisers
  logic [7:0]           sync1_ff;
  logic [7:0]           sync2_ff;
  logic [7:0]           sync3_ff;
  logic [7:0]           pin_bits_ff;
  logic [7:0]           agree;
  tael_pkg::tael_pins_s pin_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      sync3_ff <= 8'h00;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign agree = ~(sync2_ff ^ sync3_ff);

  // a change counts once second and third stage agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_bits_ff <= 8'h00;
    end else begin
      pin_bits_ff <= (pin_bits_ff & ~agree) | (sync2_ff & agree);
    end
  end

  assign pin_ff = tael_pkg::tael_pins_s'(pin_bits_ff);

  // ---- movement supervision
  logic [MN-1:0] cmd_vec;
  logic [MN-1:0] done_vec;
  logic [MN-1:0] busy_ff;
  logic [CW-1:0] cnt_ff [MN];
  logic [MN-1:0] expire;

  assign cmd_vec  = move_cmd;
  assign done_vec = {pin_ff.sl_closed_fb, pin_ff.pos_second, pin_ff.pos_first,
                     pin_ff.sl_open_fb, pin_ff.pos_centre, pin_ff.pos_centre};

  always_comb begin
    for (int i = 0; i < MN; i++) begin
      expire[i] = busy_ff[i] && !done_vec[i] && (cnt_ff[i] == CW'(TIMEOUT_CYC - 1));
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= '0;
      for (int i = 0; i < MN; i++) begin
        cnt_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < MN; i++) begin
        if (cmd_vec[i]) begin
          busy_ff[i] <= 1'b1;
          cnt_ff[i]  <= '0;
        end else if (busy_ff[i] && (done_vec[i] || expire[i])) begin
          busy_ff[i] <= 1'b0;
        end else if (busy_ff[i]) begin
          cnt_ff[i]  <= cnt_ff[i] + 1'b1;
        end
      end
    end
  end

  // ---- alarm word
  logic        key_prev_ff;
  logic        key_rise;
  logic [12:0] nxt_alarm;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_prev_ff <= 1'b0;
    end else begin
      key_prev_ff <= pin_ff.auto_key;
    end
  end

  assign key_rise = pin_ff.auto_key & ~key_prev_ff;

  always_comb begin
    nxt_alarm = tael_pkg::ALARM_RST;
    // a new timeout wins over a key press in the same cycle
    nxt_alarm[MN-1:0] = (alarm_code_ff[MN-1:0] & ~{MN{key_rise}})
                        | expire;
    nxt_alarm[tael_pkg::ALM_HANDLE] = pin_ff.handle_mounted;
    nxt_alarm[tael_pkg::ALM_EXT]    = pin_ff.pos_first & pin_ff.pos_second;
    nxt_alarm[tael_pkg::ALM_GEN]    = pin_ff.gen_fault;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_code_ff <= tael_pkg::ALARM_RST;
      auto_lock_ff  <= 1'b0;
    end else begin
      alarm_code_ff <= nxt_alarm;
      auto_lock_ff  <= |nxt_alarm[MN-1:0];
    end
  end

  // ---- alarm indicator: blink on movement failure, steady otherwise
  logic [BW-1:0] blink_cnt_ff;
  logic          blink_ph_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_ff <= '0;
      blink_ph_ff  <= 1'b0;
    end else if (blink_cnt_ff == BW'(BLINK_CYC - 1)) begin
      blink_cnt_ff <= '0;
      blink_ph_ff  <= ~blink_ph_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_led_ff <= 1'b0;
    end else if (|alarm_code_ff[MN-1:0]) begin
      alarm_led_ff <= blink_ph_ff;
    end else begin
      alarm_led_ff <= |alarm_code_ff;
    end
  end

  // ---- log entry queue, lowest pending bit first, alarms before events
  logic [12:0]               alarm_prev_ff;
  logic [tael_pkg::EV_N-1:0] ev_now;
  logic [tael_pkg::EV_N-1:0] ev_prev_ff;
  logic [PW-1:0]             pend_ff;
  logic [PW-1:0]             new_pend;
  logic [PW-1:0]             grant;
  logic [15:0]               nxt_word;
  logic [6:0]                grant_ev_idx;
  logic                      grant_alm;

  assign ev_now       = {second_supply_cond, first_supply_cond};
  assign new_pend     = {ev_now & ~ev_prev_ff, alarm_code_ff & ~alarm_prev_ff};
  assign grant        = pend_ff & (~pend_ff + 1'b1);
  assign grant_ev_idx = ev_index(grant[PW-1:tael_pkg::ALM_W]);
  assign grant_alm    = |grant[tael_pkg::ALM_W-1:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_prev_ff <= tael_pkg::ALARM_RST;
      ev_prev_ff    <= '0;
    end else begin
      alarm_prev_ff <= alarm_code_ff;
      ev_prev_ff    <= ev_now;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= (pend_ff & ~grant) | new_pend;
    end
  end

  always_comb begin
    nxt_word = tael_pkg::LOG_WORD_RST;
    if (grant_alm) begin
      nxt_word[tael_pkg::ALM_W-1:0] = grant[tael_pkg::ALM_W-1:0];
    end else begin
      nxt_word[tael_pkg::LOG_KIND_BIT] = 1'b1;
      nxt_word[tael_pkg::EV_CODE_LSB +: tael_pkg::EV_CODE_W] =
        grant_ev_idx;
      nxt_word[7:0] = event_src;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      log_wr_ff   <= 1'b0;
      log_word_ff <= tael_pkg::LOG_WORD_RST;
      log_wptr_ff <= '0;
    end else begin
      log_wr_ff   <= |grant;
      log_word_ff <= nxt_word;
      if (log_wr_ff) begin
        log_wptr_ff <= log_wptr_ff + 1'b1;
      end
    end
  end

  tael_log_mem #(
    .WIDTH (tael_pkg::LOG_W),
    .DEPTH (LOG_DEPTH),
    .AW    (LOG_AW)
  ) u_log_mem (
    .mclk       (mclk),
    .wr_en      (log_wr_ff),
    .wr_addr    (log_wptr_ff),
    .wr_data    (log_word_ff),
    .rd_addr    (log_rd_addr),
    .rd_data_ff (log_rd_data)
  );

  // ---- checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  for (genvar g = 0; g < MN; g++) begin : g_chk
    a_move_alarm: assert property (
      expire[g] |=> alarm_code_ff[g] && auto_lock_ff)
      else $error("movement timeout did not raise its alarm");
    a_timer_stop: assert property (
      busy_ff[g] && done_vec[g] && !cmd_vec[g] |=> !busy_ff[g] && (!alarm_code_ff[g] ||
      $past(alarm_code_ff[g])))
      else $error("supervision did not stop on expected status");
    a_timer_step: assert property (
      busy_ff[g] && !done_vec[g] && !expire[g] && !cmd_vec[g]
      |=> busy_ff[g] && cnt_ff[g] == $past(cnt_ff[g]) + 1'b1)
      else $error("supervision counter did not advance");
  end

  a_key_clear: assert property (
    key_rise && expire == '0 |=> alarm_code_ff[MN-1:0] == '0 && !auto_lock_ff)
    else $error("key press did not clear movement alarms");
  a_lock_hold: assert property (
    auto_lock_ff && !key_rise |=> auto_lock_ff)
    else $error("lock released without key press");
  a_handle_alarm: assert property (
    pin_ff.handle_mounted |=> alarm_code_ff[tael_pkg::ALM_HANDLE])
    else $error("handle mounted but no forced-manual alarm");
  a_ext_fault: assert property (
    pin_ff.pos_first && pin_ff.pos_second |=> alarm_code_ff[tael_pkg::ALM_EXT])
    else $error("both positions active but no external fault");
  a_gen_alarm: assert property (
    $rose(pin_ff.gen_fault) |=> $rose(alarm_code_ff[tael_pkg::ALM_GEN]))
    else $error("generator fault not flagged");
  a_alarm_word: assert property (
    log_wr_ff && !log_word_ff[15] |-> $onehot(log_word_ff[12:0]) && log_word_ff[14:13] == 2'h0)
    else $error("malformed alarm log word");
  a_event_src: assert property (
    log_wr_ff && log_word_ff[15] |-> log_word_ff[7:0] inside {[8'h01:8'h06]} &&
    log_word_ff[14:8] <= 7'h08)
    else $error("malformed event log word");
  a_first_nov: assert property (
    $rose(first_supply_cond[0]) |-> ##[1:24] log_wr_ff && log_word_ff[15:8] == 8'h80)
    else $error("first supply missing voltage not logged");
  a_entry_once: assert property (
    |grant |=> log_wr_ff && (pend_ff[$past(grant_ev_idx) + tael_pkg::ALM_W] == 1'b0 ||
    $past(grant_alm) || |$past(new_pend)))
    else $error("granted entry stayed pending");

  c_timeout:   cover property (|expire);
  c_key_clear: cover property (auto_lock_ff ##1 !auto_lock_ff);
  c_event_log: cover property (log_wr_ff && log_word_ff[15]);
  c_backlog:   cover property ($countones(pend_ff) > 1);

endmodule : tael_logger

// >>> rtl/tael_pkg.sv
package tael_pkg;

  // clock and supervision times
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned TIMEOUT_MS  = 3000;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_MS    = 250;
  localparam int unsigned BLINK_CYC   = BLINK_MS * (CLK_HZ / 1000);

  // alarm word: bit position of each weight
  localparam int unsigned ALM_W        = 13;
  localparam int unsigned MOVE_N       = 6;
  localparam int unsigned ALM_OPEN1    = 0;
  localparam int unsigned ALM_OPEN2    = 1;
  localparam int unsigned ALM_SL_OPEN  = 2;
  localparam int unsigned ALM_CLOSE1   = 3;
  localparam int unsigned ALM_CLOSE2   = 4;
  localparam int unsigned ALM_SL_CLOSE = 5;
  localparam int unsigned ALM_HANDLE   = 8;
  localparam int unsigned ALM_EXT      = 9;
  localparam int unsigned ALM_GEN      = 12;
  localparam logic [12:0] ALARM_RST    = 13'h0000;

  // supply events, index equals event code
  localparam int unsigned FIRST_EV_N  = 7;
  localparam int unsigned SECOND_EV_N = 2;
  localparam int unsigned EV_N        = FIRST_EV_N + SECOND_EV_N;

  // log word layout
  localparam int unsigned LOG_W        = 16;
  localparam int unsigned LOG_KIND_BIT = 15;
  localparam int unsigned EV_CODE_LSB  = 8;
  localparam int unsigned EV_CODE_W    = 7;
  localparam int unsigned LOG_DEPTH    = 16;
  localparam logic [15:0] LOG_WORD_RST = 16'h0000;

  typedef enum logic [7:0] {
    SRC_MANUAL   = 8'h01,
    SRC_AUTO     = 8'h02,
    SRC_TEST     = 8'h03,
    SRC_HANDLE   = 8'h04,
    SRC_FIELDBUS = 8'h05,
    SRC_DIGITAL  = 8'h06
  } tael_src_e;

  // bit 0 last, so the vector index is the alarm bit
  typedef struct packed {
    logic sl_connect;
    logic close_second;
    logic close_first;
    logic sl_disconnect;
    logic open_second;
    logic open_first;
  } tael_cmd_s;

  typedef struct packed {
    logic auto_key;
    logic gen_fault;
    logic handle_mounted;
    logic sl_closed_fb;
    logic sl_open_fb;
    logic pos_second;
    logic pos_centre;
    logic pos_first;
  } tael_pins_s;

endpackage : tael_pkg

// >>> rtl/tael_log_mem.sv
`timescale 1ns/1ns
module tael_log_mem #(
  parameter int unsigned WIDTH = tael_pkg::LOG_W,
  parameter int unsigned DEPTH = tael_pkg::LOG_DEPTH,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  // clock
  input  wire logic             mclk,
  // write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_ff
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    rd_data_ff <= mem[rd_addr];
  end

endmodule : tael_log_mem

// >>> sim/tael_switch_model.sv
`timescale 1ns/1ns
module tael_switch_model #(
  parameter int DLY = 5
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // commands and scripted faults
  input  wire tael_pkg::tael_cmd_s move_cmd,
  input  wire logic [5:0]          fail,
  // panel and plant levels
  input  wire logic                handle,
  input  wire logic                gen,
  input  wire logic                key,
  input  wire logic                both,
  // status toward the block
  output tael_pkg::tael_pins_s     pins
);
  logic [1:0] pos_ff;
  logic       sl_open_ff;
  logic [3:0] cnt_ff;
  logic [5:0] ch_ff;

  // a failing channel never moves, so its status stays put
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos_ff     <= 2'h0;
      sl_open_ff <= 1'b0;
      cnt_ff     <= 4'h0;
      ch_ff      <= 6'h00;
    end else if ((move_cmd & ~fail) != 6'h00) begin
      cnt_ff <= 4'(DLY);
      ch_ff  <= move_cmd & ~fail;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
      if (cnt_ff == 4'h1) begin
        if (ch_ff[0] | ch_ff[1]) pos_ff <= 2'h1;
        if (ch_ff[3]) pos_ff <= 2'h0;
        if (ch_ff[4]) pos_ff <= 2'h2;
        if (ch_ff[2]) sl_open_ff <= 1'b1;
        if (ch_ff[5]) sl_open_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    pins.pos_first      = (pos_ff == 2'h0) | both;
    pins.pos_centre     = (pos_ff == 2'h1);
    pins.pos_second     = (pos_ff == 2'h2) | both;
    pins.sl_open_fb     = sl_open_ff;
    pins.sl_closed_fb   = ~sl_open_ff;
    pins.handle_mounted = handle;
    pins.gen_fault      = gen;
    pins.auto_key       = key;
  end
endmodule : tael_switch_model

// >>> sim/tael_logger_test.sv
`timescale 1ns/1ns
module tael_logger_test;
  localparam int TO = 20;
  localparam int BL = 4;
  typedef struct {int ch; logic fail;} tael_row_s;

  logic                 mclk, rst_n, handle, gen, key, both;
  logic [5:0]           fail;
  tael_pkg::tael_cmd_s  move_cmd;
  tael_pkg::tael_pins_s pins;
  logic [6:0]           first_supply_cond;
  logic [1:0]           second_supply_cond;
  tael_pkg::tael_src_e  event_src;
  logic [12:0]          alarm_code_ff;
  logic                 alarm_led_ff, auto_lock_ff, log_wr_ff;
  logic [15:0]          log_word_ff, log_rd_data, w;
  logic [3:0]           log_wptr_ff, log_rd_addr;
  int                   n_fail, compares, cycles;
  logic                 seen0, seen1;
  tael_row_s            rows [12] = '{'{0,1}, '{0,0}, '{3,1}, '{4,1}, '{4,0}, '{1,1},
                                      '{1,0}, '{3,0}, '{2,1}, '{2,0}, '{5,1}, '{5,0}};

  tael_logger #(.TIMEOUT_CYC(TO), .BLINK_CYC(BL), .LOG_DEPTH(16)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .move_cmd(move_cmd), .pins(pins),
    .first_supply_cond(first_supply_cond), .second_supply_cond(second_supply_cond),
    .event_src(event_src), .alarm_code_ff(alarm_code_ff), .alarm_led_ff(alarm_led_ff),
    .auto_lock_ff(auto_lock_ff), .log_wr_ff(log_wr_ff), .log_word_ff(log_word_ff),
    .log_wptr_ff(log_wptr_ff), .log_rd_addr(log_rd_addr), .log_rd_data(log_rd_data));

  tael_switch_model #(.DLY(5)) u_plant (
    .mclk(mclk), .rst_n(rst_n), .move_cmd(move_cmd), .fail(fail), .handle(handle),
    .gen(gen), .key(key), .both(both), .pins(pins));

  task automatic conclude();
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #2;
    end
  endtask : tick

  // bounded wait for the next log entry
  task automatic wait_log(output logic [15:0] word);
    int i;
    word = 16'hFFFF;
    for (i = 0; i < 40; i++) begin
      tick(1);
      if (log_wr_ff === 1'b1) begin
        word = log_word_ff;
        break;
      end
    end
  endtask : wait_log

  task automatic press_key();
    key = 1'b1;
    tick(8);
    key = 1'b0;
    tick(8);
  endtask : press_key

  task automatic pulse(input logic [5:0] c);
    move_cmd = c;
    tick(1);
    move_cmd = 6'h00;
  endtask : pulse

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    rst_n = 1'b0; handle = 1'b0; gen = 1'b0; key = 1'b0; both = 1'b0; fail = 6'h00;
    move_cmd = 6'h00; first_supply_cond = 7'h00; second_supply_cond = 2'h0;
    event_src = tael_pkg::SRC_AUTO; log_rd_addr = 4'h0;
    n_fail = 0; compares = 0; cycles = 0;
    tick(12);
    chk({2'h0, alarm_code_ff, alarm_led_ff}, 16'h0000);
    chk({log_wr_ff, auto_lock_ff, log_wptr_ff}, 16'h0000);
    rst_n = 1'b1;
    tick(6);
    foreach (rows[r]) begin
      fail = {5'h00, rows[r].fail} << rows[r].ch;
      pulse(6'h01 << rows[r].ch);
      if (rows[r].fail) begin
        wait_log(w);
        chk(w, 16'h0001 << rows[r].ch);
        chk({3'h0, alarm_code_ff}, 16'h0001 << rows[r].ch);
        chk({15'h0000, auto_lock_ff}, 16'h0001);
        seen0 = 1'b0;
        seen1 = 1'b0;
        repeat (3 * BL) begin
          tick(1);
          if (alarm_led_ff === 1'b0) seen0 = 1'b1;
          if (alarm_led_ff === 1'b1) seen1 = 1'b1;
        end
        chk({14'h0000, seen0, seen1}, 16'h0003);
        press_key();
        chk({2'h0, alarm_code_ff, auto_lock_ff}, 16'h0000);
      end else begin
        tick(2 * TO);
        chk({3'h0, alarm_code_ff}, 16'h0000);
      end
    end
    // level alarms follow their inputs, indicator steady
    for (int k = 0; k < 3; k++) begin
      handle = (k == 0);
      both = (k == 1);
      gen = (k == 2);
      wait_log(w);
      chk(w, (k == 2) ? 16'h1000 : (16'h0100 << k));
      tick(2);
      chk({3'h0, alarm_code_ff}, w);
      seen0 = 1'b0;
      repeat (3 * BL) begin
        tick(1);
        if (alarm_led_ff !== 1'b1) seen0 = 1'b1;
      end
      chk({15'h0000, seen0}, 16'h0000);
      handle = 1'b0;
      both = 1'b0;
      gen = 1'b0;
      tick(8);
      chk({3'h0, alarm_code_ff}, 16'h0000);
    end
    // supply events, every code and every source, read back from the log
    for (int k = 0; k < 9; k++) begin
      event_src = tael_pkg::tael_src_e'(8'(k % 6 + 1));
      if (k < 7) first_supply_cond = 7'h01 << k;
      else second_supply_cond = 2'h1 << (k - 7);
      wait_log(w);
      chk(w, {1'b1, 7'(k), 8'(k % 6 + 1)});
      tick(1);
      log_rd_addr = log_wptr_ff - 4'h1;
      tick(1);
      chk(log_rd_data, w);
      first_supply_cond = 7'h00;
      second_supply_cond = 2'h0;
      tick(2);
    end
    // two failures at once give two entries, weights ORed
    fail = 6'h05;
    pulse(6'h05);
    wait_log(w);
    chk(w, 16'h0001);
    tick(1);
    chk({log_wr_ff, log_word_ff[14:0]}, 16'h8004);
    handle = 1'b1;
    tick(8);
    chk({3'h0, alarm_code_ff}, 16'h0105);
    press_key();
    chk({2'h0, alarm_code_ff, auto_lock_ff}, 16'h0200);
    handle = 1'b0;
    tick(8);
    // reset in mid-run drops held alarms and cancels running supervision
    fail = 6'h01;
    pulse(6'h01);
    wait_log(w);
    chk(w, 16'h0001);
    pulse(6'h01);
    tick(4);
    rst_n = 1'b0;
    tick(2);
    chk({2'h0, alarm_code_ff, alarm_led_ff}, 16'h0000);
    chk({log_wr_ff, auto_lock_ff, log_wptr_ff}, 16'h0000);
    rst_n = 1'b1;
    tick(1);
    chk({2'h0, alarm_code_ff, auto_lock_ff}, 16'h0000);
    tick(2 * TO);
    chk({2'h0, alarm_code_ff, auto_lock_ff}, 16'h0000);
    conclude();
  end
endmodule : tael_logger_test
